// ---- core/lfe_ctl.sv ----
// controller end: apb registers driving the device link
`timescale 1ns/1ps
`default_nettype none
module lfe_ctl (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link side
  lfe_if.ctl               lk
);
  // ************************************************************
  // apb decode
  // ************************************************************
  lfe_pkg::lfe_cst_t st_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic [7:0]  wd_r;
  logic [4:0]  ad_r;
  logic        we_r;
  logic [7:0]  rd_r;
  logic        refused_r;
  logic        blocked_r;
  logic [11:0] link_r;
  logic        dirty_r;
  logic        req_r;
  logic        a1_r;
  logic        a2_r;
  logic        rst_n_r;
  logic        stop_n_r;
  logic [2:0]  div_r;
  logic        lclk_r;
  wire setup   = psel & ~penable;
  wire wr      = psel & penable & pready_r & pwrite;
  wire sel_cmd = (paddr == lfe_pkg::APB_CMD);
  wire sel_lnk = (paddr == lfe_pkg::APB_LINK);
  wire idle    = (st_r == lfe_pkg::LFE_IDLE);
  wire [4:0] n_ad = pwdata[lfe_pkg::CMD_ADDR_LSB +: 5];
  wire [7:0] n_wd = pwdata[7:0];
  wire n_we    = pwdata[lfe_pkg::CMD_WE];
  wire n_freq  = (n_ad == lfe_pkg::OFS_FREQ0) | (n_ad == lfe_pkg::OFS_FREQ1);
  wire n_third_generation  = (n_wd[3:0] >= lfe_pkg::THIRD_GENERATION_LO) & (n_wd[3:0] <= lfe_pkg::THIRD_GENERATION_HI);
  wire rs_ok   = link_r[lfe_pkg::LINK_RETRY] & link_r[lfe_pkg::LINK_SCR];
  wire bad     = n_we & n_freq & n_third_generation & ~rs_ok;
  wire go      = wr & sel_cmd & pwdata[lfe_pkg::CMD_GO] & idle;
  wire start   = go & ~bad;
  // a pending frequency plus skew select would stall relock on stop
  wire stop_ok = ~(dirty_r & link_r[lfe_pkg::LINK_SKEW]);
  wire stop_rq = link_r[lfe_pkg::LINK_STOP];
  wire blk     = idle & stop_rq & ~stop_ok & stop_n_r;
  wire [31:0] rd_mux =
    sel_cmd ? {15'h0000, we_r, 3'h0, ad_r, wd_r} :
    (paddr == lfe_pkg::APB_STAT) ? {21'h000000, blocked_r, refused_r, ~idle, rd_r} :
    sel_lnk ? {20'h00000, link_r} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      link_r   <= {lfe_pkg::T0_RST, 8'h00};
    end
    else
    begin
      pready_r <= setup;
      prdata_r <= setup ? rd_mux : prdata_r;
      link_r   <= (wr & sel_lnk) ? pwdata[11:0] : link_r;
    end
  end

  // ************************************************************
  // access sequencer and link drive
  // ************************************************************
  wire ack_s = a2_r;
  lfe_pkg::lfe_cst_t st_nxt;
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      lfe_pkg::LFE_IDLE: st_nxt = start ? lfe_pkg::LFE_REQ : lfe_pkg::LFE_IDLE;
      lfe_pkg::LFE_REQ:  st_nxt = ack_s ? lfe_pkg::LFE_DROP : lfe_pkg::LFE_REQ;
      lfe_pkg::LFE_DROP: st_nxt = ack_s ? lfe_pkg::LFE_DROP : lfe_pkg::LFE_IDLE;
      default:           st_nxt = lfe_pkg::LFE_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r      <= lfe_pkg::LFE_IDLE;
      wd_r      <= 8'h00;
      ad_r      <= 5'h00;
      we_r      <= 1'b0;
      rd_r      <= 8'h00;
      req_r     <= 1'b0;
      refused_r <= 1'b0;
      blocked_r <= 1'b0;
      dirty_r   <= 1'b0;
      a1_r      <= 1'b0;
      a2_r      <= 1'b0;
      rst_n_r   <= 1'b1;
      stop_n_r  <= 1'b1;
    end
    else
    begin
      st_r      <= st_nxt;
      wd_r      <= start ? n_wd : wd_r;
      ad_r      <= start ? n_ad : ad_r;
      we_r      <= start ? n_we : we_r;
      rd_r      <= (st_r == lfe_pkg::LFE_REQ && ack_s) ? lk.rdata : rd_r;
      req_r     <= (st_nxt == lfe_pkg::LFE_REQ);
      refused_r <= (go & bad) | (refused_r & ~(wr & sel_cmd));
      blocked_r <= blk | (blocked_r & ~(wr & sel_cmd));
      dirty_r   <= (start & n_we & n_freq) | (dirty_r & stop_n_r & rst_n_r);
      a1_r      <= lk.ack;
      a2_r      <= a1_r;
      // reset and stop only move between accesses
      rst_n_r   <= idle ? ~link_r[lfe_pkg::LINK_RST] : rst_n_r;
      stop_n_r  <= idle ? ~(stop_rq & stop_ok) : stop_n_r;
    end
  end

  // ************************************************************
  // link clock divider
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_r  <= 3'h0;
      lclk_r <= 1'b0;
    end
    else
    begin
      div_r  <= (div_r == 3'(lfe_pkg::LCLK_HALF - 1)) ? 3'h0 : div_r + 3'h1;
      lclk_r <= (div_r == 3'(lfe_pkg::LCLK_HALF - 1)) ? ~lclk_r : lclk_r;
    end
  end

  assign lk.link_clk    = lclk_r;
  assign lk.link_rst_n  = rst_n_r;
  assign lk.link_stop_n = stop_n_r;
  assign lk.req         = req_r;
  assign lk.we          = we_r;
  assign lk.addr        = ad_r;
  assign lk.wdata       = wd_r;
  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = 1'b0;
endmodule
`default_nettype wire

// ---- core/lfe_dev.sv ----
// device end: per-link frequency, error log, capability and feature registers
`timescale 1ns/1ps
`default_nettype none
module lfe_dev #(
  parameter int          NUM_LINKS   = 2,
  parameter bit          IS_HOST     = 1'b1,
  parameter bit          AC_COUPLED  = 1'b0,
  parameter logic [31:0] CAP_MASK    = 32'h0001_0001,
  parameter logic [1:0]  VENDOR_FREQ = 2'b00,
  parameter logic [4:0]  FEAT_RO     = 5'h0b,
  parameter bit          FEAT_SRCID  = 1'b0,
  parameter bit          EXT_REGS    = 1'b1,
  parameter bit          REORDER_HW1 = 1'b0,
  parameter bit          UPCFG_HW0   = 1'b0,
  parameter logic [2:0]  CHECKS      = 3'b111,
  parameter int          SHORT_CYC   = lfe_pkg::CTL_SHORT_CYC,
  parameter int          LONG_CYC    = lfe_pkg::CTL_LONG_CYC,
  parameter int          EXT_CYC     = lfe_pkg::EXT_CTL_CYC
) (
  // clock and cold reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // link side
  lfe_if.dev                   lk,
  // error events and control lines
  input  wire logic [1:0]      prot_evt,
  input  wire logic [1:0]      ovf_evt,
  input  wire logic [1:0]      eoc_evt,
  input  wire logic [1:0]      ctl_line,
  // mode inputs
  input  wire logic            first_generation_mode,
  input  wire logic            sync_mode,
  input  wire logic            upcfg_req,
  // status outputs
  output logic [1:0][3:0]      tx_freq,
  output logic                 freq_is_limit,
  output logic                 reorder_keep,
  output logic                 upcfg_en,
  output logic                 upcfg_reject,
  output logic                 ctl_init_ok
);
  // ************************************************************
  // input synchronisers and link clock sampling
  // ************************************************************
  localparam int CW = lfe_pkg::CNT_W;
  localparam int HW = lfe_pkg::HOLD_W;
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  logic       lclk_d_r;
  logic       lrst_n_r;
  logic       lstop_n_r;
  logic       lrst_p_r;
  logic       lstop_p_r;
  logic       ack_r;
  logic [7:0] rdata_r;
  wire        lclk_rise = s2_r[5] & ~lclk_d_r;
  wire        req_s     = s2_r[2];
  wire        acc       = req_s & ~ack_r;
  wire        warm      = ~lrst_n_r;
  wire        warm_fall = lrst_p_r & ~lrst_n_r;
  wire        stop_fall = lstop_p_r & ~lstop_n_r;
  wire        rd_acc    = acc & ~lk.we;
  wire        wr_acc    = acc & lk.we;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r      <= lfe_pkg::SYNC_RST;
      s2_r      <= lfe_pkg::SYNC_RST;
      lclk_d_r  <= 1'b0;
      lrst_n_r  <= 1'b1;
      lstop_n_r <= 1'b1;
      lrst_p_r  <= 1'b1;
      lstop_p_r <= 1'b1;
    end
    else
    begin
      s1_r      <= {lk.link_clk, lk.link_rst_n, lk.link_stop_n, lk.req, ctl_line};
      s2_r      <= s1_r;
      lclk_d_r  <= s2_r[5];
      lrst_n_r  <= lclk_rise ? s2_r[4] : lrst_n_r;
      lstop_n_r <= lclk_rise ? s2_r[3] : lstop_n_r;
      lrst_p_r  <= lrst_n_r;
      lstop_p_r <= lstop_n_r;
    end
  end

  // ************************************************************
  // frequency apply timing
  // ************************************************************
  logic [HW-1:0] hold_r;
  // early edge of reset may reach the peer late; keep clock steady meanwhile
  wire  [HW-1:0] hold_nxt = (warm_fall && first_generation_mode) ? HW'(lfe_pkg::HOLD_CYC) :
                            (hold_r != '0) ? hold_r - HW'(1) : hold_r;
  wire           apply = (warm_fall & ~first_generation_mode) | (hold_r == HW'(1)) | stop_fall;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_r <= '0;
    else
      hold_r <= hold_nxt;
  end

  // ************************************************************
  // per-link frequency and error registers
  // ************************************************************
  logic [7:0]  fbyte [2];
  logic [15:0] cap_v [2];
  logic [3:0]  act_r [2];

  for (genvar l = 0; l < 2; l++)
  begin : g_link
    if (l < NUM_LINKS)
    begin : g_on
      localparam logic [4:0] OFS = (l == 0) ? lfe_pkg::OFS_FREQ0 : lfe_pkg::OFS_FREQ1;
      localparam logic [3:0] FRST = AC_COUPLED ? lfe_pkg::FREQ_AC_RST : lfe_pkg::FREQ_RST;
      logic [2:0]    err_r;
      logic          sel_r;
      logic [3:0]    pend_r;
      logic [CW-1:0] cnt_r;
      wire           hit_b  = (lk.addr == OFS);
      wire [CW-1:0]  lim    = sel_r ? CW'(LONG_CYC) : CW'(SHORT_CYC);
      wire           ctl_lo = ~s2_r[l];
      wire           to_hit = ctl_lo & (cnt_r == lim - CW'(1));
      wire [CW-1:0]  cnt_nxt = !ctl_lo ? '0 : (cnt_r == lim) ? cnt_r : cnt_r + CW'(1);
      wire [2:0]     setv = {eoc_evt[l], ovf_evt[l], prot_evt[l] | to_hit} & CHECKS;
      wire [2:0]     clrv = {3{rd_acc & hit_b}};
      // set beats a clear-on-read in the same cycle
      wire [2:0]     err_nxt = (err_r & ~clrv) | setv;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          err_r    <= 3'h0;
          sel_r    <= 1'b0;
          pend_r   <= FRST;
          act_r[l] <= FRST;
          cnt_r    <= '0;
        end
        else
        begin
          err_r    <= err_nxt;
          sel_r    <= warm ? 1'b0 : (wr_acc & hit_b) ? lk.wdata[lfe_pkg::ERR_CTLSEL] : sel_r;
          pend_r   <= (wr_acc & hit_b) ? lk.wdata[3:0] : pend_r;
          act_r[l] <= apply ? pend_r : act_r[l];
          cnt_r    <= cnt_nxt;
        end
      end
      assign fbyte[l] = {sel_r, err_r, pend_r};
      assign cap_v[l] = {VENDOR_FREQ[l], CAP_MASK[16*l+1 +: 14], 1'b1};
    end
    else
    begin : g_off
      assign fbyte[l] = 8'h00;
      assign cap_v[l] = 16'h0000;
      assign act_r[l] = 4'h0;
    end
    assign tx_freq[l] = act_r[l];
  end

  // ************************************************************
  // feature register
  // ************************************************************
  logic reorder_r;
  logic upcfg_r;
  logic [CW-1:0] ext_r;
  logic ctl_ok_r;
  logic lim_r;
  logic rej_r;
  wire  wr_f0   = wr_acc & (lk.addr == lfe_pkg::OFS_FEAT);
  wire  wr_f1   = wr_acc & (lk.addr == lfe_pkg::OFS_FEAT + 5'h01) & IS_HOST;
  wire  reo_v   = REORDER_HW1 | reorder_r;
  wire  upc_v   = ~UPCFG_HW0 & upcfg_r;
  // bits above 9 are reserved and the high byte vanishes outside hosts
  wire [15:0] feat = {6'h00, upc_v & IS_HOST, EXT_REGS & IS_HOST, 1'b0,
                      FEAT_SRCID, reo_v, FEAT_RO};
  wire  ext_done = ~FEAT_RO[3] | (ext_r >= CW'(EXT_CYC));
  wire [CW-1:0] ext_nxt = (~lstop_n_r | ~s2_r[0]) ? '0 : ext_done ? ext_r : ext_r + CW'(1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reorder_r <= 1'b0;
      upcfg_r   <= 1'b1;
      ext_r     <= '0;
      ctl_ok_r  <= 1'b0;
      lim_r     <= 1'b0;
      rej_r     <= 1'b0;
    end
    else
    begin
      reorder_r <= warm ? 1'b0 : wr_f0 ? lk.wdata[lfe_pkg::FEAT_REORDER] : reorder_r;
      upcfg_r   <= warm ? 1'b1 : wr_f1 ? lk.wdata[lfe_pkg::FEAT_UPCFG-8] : upcfg_r;
      ext_r     <= ext_nxt;
      ctl_ok_r  <= lstop_n_r & ext_done;
      lim_r     <= ~sync_mode;
      rej_r     <= upcfg_req & ~upc_v;
    end
  end

  // ************************************************************
  // register access answer
  // ************************************************************
  wire       two = (NUM_LINKS > 1);
  wire [7:0] rd_mux =
    (lk.addr == lfe_pkg::OFS_FREQ0)         ? fbyte[0] :
    (lk.addr == lfe_pkg::OFS_CAP0)          ? cap_v[0][7:0] :
    (lk.addr == lfe_pkg::OFS_CAP0 + 5'h01)  ? cap_v[0][15:8] :
    (lk.addr == lfe_pkg::OFS_FEAT)          ? feat[7:0] :
    (lk.addr == lfe_pkg::OFS_FEAT + 5'h01)  ? feat[15:8] :
    (lk.addr == lfe_pkg::OFS_FREQ1 && two)  ? fbyte[1] :
    (lk.addr == lfe_pkg::OFS_CAP1 && two)   ? cap_v[1][7:0] :
    (lk.addr == lfe_pkg::OFS_CAP1 + 5'h01 && two) ? cap_v[1][15:8] : 8'h00;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_r   <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      ack_r   <= req_s;
      rdata_r <= acc ? rd_mux : rdata_r;
    end
  end

  assign lk.ack        = ack_r;
  assign lk.rdata      = rdata_r;
  assign freq_is_limit = lim_r;
  assign reorder_keep  = reo_v;
  assign upcfg_en      = upc_v;
  assign upcfg_reject  = rej_r;
  assign ctl_init_ok   = ctl_ok_r;
endmodule
`default_nettype wire

// ---- core/lfe_if.sv ----
// link between register device and its controller
`timescale 1ns/1ps
`default_nettype none
interface lfe_if;
  logic       link_clk;
  logic       link_rst_n;
  logic       link_stop_n;
  logic       req;
  logic       we;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  modport dev (
    input  link_clk, link_rst_n, link_stop_n, req, we, addr, wdata,
    output ack, rdata
  );
  modport ctl (
    output link_clk, link_rst_n, link_stop_n, req, we, addr, wdata,
    input  ack, rdata
  );
endinterface
`default_nettype wire

// ---- core/lfe_pkg.sv ----
// shared constants for the link frequency, error and feature register block
package lfe_pkg;
  localparam int CLK_NS = 4;
  // device byte offsets
  localparam logic [4:0] OFS_FREQ0 = 5'h09;
  localparam logic [4:0] OFS_CAP0  = 5'h0a;
  localparam logic [4:0] OFS_FEAT  = 5'h0c;
  localparam logic [4:0] OFS_FREQ1 = 5'h11;
  localparam logic [4:0] OFS_CAP1  = 5'h12;
  // field positions
  localparam int ERR_CTLSEL   = 7;
  localparam int FEAT_REORDER = 5;
  localparam int FEAT_UPCFG   = 9;
  // reset values and codes
  localparam logic [3:0] FREQ_RST    = 4'h0;
  localparam logic [3:0] FREQ_AC_RST = 4'h7;
  localparam logic [3:0] THIRD_GENERATION_LO     = 4'h7;
  localparam logic [3:0] THIRD_GENERATION_HI     = 4'he;
  localparam logic [5:0] SYNC_RST    = 6'h1b;
  localparam logic [3:0] T0_RST      = 4'hf;
  // timing
  localparam int HOLD_NS      = 2000;
  localparam int HOLD_CYC     = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_W       = 9;
  localparam int CTL_SHORT_NS = 1000000;
  localparam int CTL_SHORT_CYC = CTL_SHORT_NS / CLK_NS;
  localparam int CTL_LONG_NS  = 1000000000;
  localparam int CTL_LONG_CYC = CTL_LONG_NS / CLK_NS;
  localparam int EXT_CTL_NS   = 50000;
  localparam int EXT_CTL_CYC  = (EXT_CTL_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W        = 28;
  localparam int LCLK_HALF    = 4;
  // controller apb map
  localparam logic [11:0] APB_CMD  = 12'h000;
  localparam logic [11:0] APB_STAT = 12'h004;
  localparam logic [11:0] APB_LINK = 12'h008;
  localparam int CMD_GO = 31;
  localparam int CMD_WE = 16;
  localparam int CMD_ADDR_LSB = 8;
  localparam int STAT_BUSY = 8;
  localparam int STAT_REFUSED = 9;
  localparam int STAT_BLOCKED = 10;
  localparam int LINK_RST = 0;
  localparam int LINK_STOP = 1;
  localparam int LINK_RETRY = 2;
  localparam int LINK_SCR = 3;
  localparam int LINK_SKEW = 4;
  localparam int LINK_T0_LSB = 8;
  typedef enum logic [1:0] {
    LFE_IDLE = 2'b00,
    LFE_REQ  = 2'b01,
    LFE_DROP = 2'b11
  } lfe_cst_t;
endpackage

// ---- dv/lfe_bench.sv ----
// self-checking bench: controller and device joined over the link
`timescale 1ns/1ps
`default_nettype none
module lfe_bench;
  // ************************************************
  // signals
  // ************************************************
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, q;
  logic [1:0]      prot_evt, ovf_evt, eoc_evt, ctl_line;
  logic            first_generation_mode, sync_mode, upcfg_req;
  logic [1:0][3:0] tx_freq;
  logic            freq_is_limit, reorder_keep, upcfg_en, upcfg_reject, ctl_init_ok;
  int              err_total, compares, i;
  typedef struct {logic w; logic [4:0] a; logic [7:0] d; logic [7:0] e;} lfe_row_t;
  lfe_row_t        rows[10];
  lfe_if lk ();
  lfe_ctl u_lfe_ctl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lk(lk));
  // short timeouts keep the run small
  lfe_dev #(.CAP_MASK(32'h8002_80fe), .VENDOR_FREQ(2'b10), .SHORT_CYC(20), .LONG_CYC(40),
    .EXT_CYC(10)) u_lfe_dev (.pclk(pclk), .presetn(presetn), .lk(lk),
    .prot_evt(prot_evt), .ovf_evt(ovf_evt), .eoc_evt(eoc_evt), .ctl_line(ctl_line),
    .first_generation_mode(first_generation_mode), .sync_mode(sync_mode), .upcfg_req(upcfg_req), .tx_freq(tx_freq),
    .freq_is_limit(freq_is_limit), .reorder_keep(reorder_keep), .upcfg_en(upcfg_en),
    .upcfg_reject(upcfg_reject), .ctl_init_ok(ctl_init_ok));
  lfe_properties u_lfe_properties (
    .pclk(pclk), .presetn(presetn), .link_clk(lk.link_clk), .link_rst_n(lk.link_rst_n),
    .link_stop_n(lk.link_stop_n), .req(lk.req), .we(lk.we), .addr(lk.addr), .wdata(lk.wdata),
    .ack(lk.ack), .rdata(lk.rdata));
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ************************************************
  // tasks
  // ************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50)
    begin
      chk(32'h0, 32'h1);
      report_and_stop();
    end
  endtask
  // device access through the command register; q ends as the status word
  task automatic dev(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    apb(1'b1, lfe_pkg::APB_CMD, {1'b1, 14'h0, w, 3'h0, a, d});
    for (n = 0; n < 40; n++)
    begin
      apb(1'b0, lfe_pkg::APB_STAT, 32'h0);
      if (q[lfe_pkg::STAT_BUSY] === 1'b0) break;
    end
    if (n == 40)
    begin
      chk(32'h0, 32'h1);
      report_and_stop();
    end
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    dev(1'b0, a, 8'h00);
    chk(q[7:0], e);
  endtask
  task automatic wait_tx(input int k, input logic [3:0] v);
    int n;
    for (n = 0; n < 800; n++)
    begin
      @(posedge pclk);
      if (tx_freq[k] === v) break;
    end
    chk(tx_freq[k], v);
    if (n == 800) report_and_stop();
  endtask
  task automatic pulse_upcfg(input logic e);
    @(posedge pclk);
    upcfg_req <= 1'b1;
    @(posedge pclk);
    upcfg_req <= 1'b0;
    @(negedge pclk);
    chk(upcfg_reject, e);
  endtask
  // ************************************************
  // main sequence
  // ************************************************
  initial
  begin
    {presetn, psel, penable, pwrite, upcfg_req, first_generation_mode} = 6'h00;
    {paddr, pwdata} = 44'h0;
    {prot_evt, ovf_evt, eoc_evt} = 6'h00;
    ctl_line = 2'b11;
    sync_mode = 1'b1;
    err_total = 0;
    compares = 0;
    rows = '{'{0, 5'h0a, 8'h00, 8'hff}, '{0, 5'h0b, 8'h00, 8'h00}, '{1, 5'h0a, 8'h00, 8'hff},
      '{0, 5'h12, 8'h00, 8'h03}, '{0, 5'h13, 8'h00, 8'h80}, '{0, 5'h0c, 8'h00, 8'h0b},
      '{0, 5'h0d, 8'h00, 8'h03}, '{1, 5'h0c, 8'hff, 8'h2b}, '{1, 5'h0d, 8'h00, 8'h01},
      '{1, 5'h09, 8'h83, 8'h83}};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, lfe_pkg::APB_LINK, 32'h0);
    chk(q, 32'h0000_0f00);
    apb(1'b0, 12'h0f0, 32'h0);
    chk(q, 32'h0);
    chk(pslverr, 32'h0);
    chk(tx_freq, 8'h00);
    chk(upcfg_en, 1'b1);
    $display("reset test done");
    for (i = 0; i < 10; i++)
    begin
      if (rows[i].w) dev(1'b1, rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    chk(reorder_keep, 1'b1);
    chk(upcfg_en, 1'b0);
    chk(tx_freq[0], 4'h0);
    pulse_upcfg(1'b1);
    $display("table test done");
    // warm reset applies the pending code and restores the warm fields
    apb(1'b1, lfe_pkg::APB_LINK, 32'h0f01);
    wait_tx(0, 4'h3);
    apb(1'b1, lfe_pkg::APB_LINK, 32'h0f00);
    rd_chk(5'h09, 8'h03);
    rd_chk(5'h0c, 8'h0b);
    rd_chk(5'h0d, 8'h03);
    pulse_upcfg(1'b0);
    $display("warm reset test done");
    @(posedge pclk);
    {prot_evt, ovf_evt, eoc_evt} <= 6'b10_01_01;
    @(posedge pclk);
    {prot_evt, ovf_evt, eoc_evt} <= 6'h00;
    rd_chk(5'h09, 8'h63);
    rd_chk(5'h09, 8'h03);
    rd_chk(5'h11, 8'h10);
    rd_chk(5'h11, 8'h00);
    // control line low 30 cycles: past the short limit, inside the long one
    for (i = 0; i < 2; i++)
    begin
      @(posedge pclk);
      ctl_line <= 2'b10;
      repeat (30) @(posedge pclk);
      ctl_line <= 2'b11;
      rd_chk(5'h09, i ? 8'h83 : 8'h13);
      if (i == 0) dev(1'b1, 5'h09, 8'h83);
    end
    $display("error log test done");
    dev(1'b1, 5'h09, 8'h89);
    chk(q[lfe_pkg::STAT_REFUSED], 1'b1);
    rd_chk(5'h09, 8'h83);
    apb(1'b1, lfe_pkg::APB_LINK, 32'h0f0c);
    dev(1'b1, 5'h09, 8'h89);
    rd_chk(5'h09, 8'h89);
    apb(1'b1, lfe_pkg::APB_LINK, 32'h0f1c);
    apb(1'b1, lfe_pkg::APB_LINK, 32'h0f1e);
    apb(1'b0, lfe_pkg::APB_STAT, 32'h0);
    chk(q[lfe_pkg::STAT_BLOCKED], 1'b1);
    repeat (100) @(posedge pclk);
    chk(tx_freq[0], 4'h3);
    ctl_line <= 2'b10;
    apb(1'b1, lfe_pkg::APB_LINK, 32'h0f0e);
    wait_tx(0, 4'h9);
    apb(1'b1, lfe_pkg::APB_LINK, 32'h0f0c);
    repeat (30) @(posedge pclk);
    chk(ctl_init_ok, 1'b0);
    ctl_line <= 2'b11;
    for (i = 0; i < 60 && ctl_init_ok !== 1'b1; i++) @(posedge pclk);
    chk(ctl_init_ok, 1'b1);
    $display("stop test done");
    first_generation_mode <= 1'b1;
    dev(1'b1, 5'h09, 8'h05);
    apb(1'b1, lfe_pkg::APB_LINK, 32'h0f0d);
    repeat (lfe_pkg::HOLD_CYC - 50) @(posedge pclk);
    chk(tx_freq[0], 4'h9);
    wait_tx(0, 4'h5);
    apb(1'b1, lfe_pkg::APB_LINK, 32'h0f0c);
    sync_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(freq_is_limit, 1'b0);
    sync_mode <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(freq_is_limit, 1'b1);
    $display("hold and mode test done");
    // cold reset mid-run: log bits set by the long control-line low and codes must clear
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk(tx_freq, 8'h00);
    chk(upcfg_en, 1'b1);
    rd_chk(5'h09, 8'h00);
    $display("cold reset test done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- dv/lfe_properties.sv ----
// concurrent checks on the link between controller and device
`timescale 1ns/1ps
`default_nettype none
module lfe_properties #(
  parameter logic [4:0] FEAT_RO    = 5'h0b,
  parameter bit         FEAT_SRCID = 1'b0,
  parameter bit         EXT_REGS   = 1'b1
) (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // link signals
  input wire logic       link_clk,
  input wire logic       link_rst_n,
  input wire logic       link_stop_n,
  input wire logic       req,
  input wire logic       we,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ************************************************
  // sequences
  // ************************************************
  sequence s_new_ack;
    $rose(ack);
  endsequence
  sequence s_read(logic [4:0] a);
    req && !we && addr == a;
  endsequence
  // ************************************************
  // handshake
  // ************************************************
  chk_payload_stable: assert property (req && !ack |=> req && $stable({we, addr, wdata}))
    else $error("link request dropped or changed before ack");
  chk_ack_bound: assert property ($rose(req) |-> ##[1:16] ack)
    else $error("link ack missing after request");
  chk_ack_hold: assert property (ack && req |=> ack)
    else $error("link ack fell while request high");
  chk_ack_release: assert property ($fell(req) |-> ##[1:16] !ack)
    else $error("link ack stuck after request fell");
  chk_no_early_req: assert property (ack && !req |=> !req)
    else $error("new request before ack released");
  chk_rdata_hold: assert property (ack |=> !ack || $stable(rdata))
    else $error("read data moved while ack high");
  // reset and stop must not move while an access is open
  chk_quiet_access: assert property (req |=> !req || $stable({link_rst_n, link_stop_n}))
    else $error("reset or stop changed during access");
  chk_clk_period: assert property ($rose(link_clk) |-> link_clk[*4] ##1 !link_clk[*4] ##1 link_clk)
    else $error("link clock period wrong");
  // ************************************************
  // read-only contents
  // ************************************************
  chk_cap_bit0: assert property ((s_read(5'h0a) or s_read(5'h12)) ##0 s_new_ack |-> rdata[0])
    else $error("capability bit 0 clear");
  chk_feat_ro: assert property (s_read(5'h0c) ##0 s_new_ack
    |-> rdata[4:0] == FEAT_RO && rdata[6] == FEAT_SRCID && !rdata[7])
    else $error("feature read-only bits wrong");
  chk_ext_regs: assert property (s_read(5'h0d) ##0 s_new_ack
    |-> rdata[0] == EXT_REGS && rdata[7:2] == 6'h00)
    else $error("feature high byte wrong");
endmodule
`default_nettype wire
